// >>> logic/nvm_ctrl_pkg.sv
// Package for the nonvolatile memory clock divider and options block.
// Assumes an APB slave with 32-bit data and a 20 MHz bus clock.
package nvm_ctrl_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CLOCK_DIVIDER = 12'h000;
  localparam logic [11:0] ADDR_OPTIONS = 12'h004;
  localparam logic [11:0] ADDR_KEY_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_KEY_DATA = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_PROTECT = 12'h014;
  // Divider register fields
  localparam int LOADED_FLAG_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIV_WIDTH = 6;
  localparam logic [7:0] CLOCK_DIVIDER_RESET = 8'h00;
  localparam int PRESCALE_RATIO = 8;
  // Options register fields
  localparam int KEY_ENABLE_BIT = 7;
  localparam int REDIRECT_DISABLE_BIT = 6;
  localparam logic [7:0] OPTIONS_RESET = 8'hff;
  // Backdoor key length in bytes
  localparam int KEY_BYTES = 8;
  // Status register fields
  localparam int STAT_SECURE_BIT = 0;
  localparam int STAT_OP_ALLOWED_BIT = 1;
  localparam int STAT_REDIRECT_BIT = 2;
  localparam int STAT_KEY_ARMED_BIT = 3;
  // Timing clock window
  localparam int TIMING_CLK_MIN_KHZ = 150;
  localparam int TIMING_CLK_MAX_KHZ = 200;
  localparam int CORE_CLK_KHZ = 20000;
endpackage

// >>> logic/nvm_timing_divider.sv
// Divides the bus clock into the nonvolatile timing pulse train.
// Assumes the divisor settings are stable once the divisor is loaded.
`timescale 1ns/1ns
module nvm_timing_divider #(
  parameter int DIV_W = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic prescale_i,
  input wire logic [DIV_W-1:0] divisor_i,
  output logic tick_o
);
  import nvm_ctrl_pkg::*;
  logic [2:0] pre_cnt_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic pre_tick;
  // Refuse divisor widths the counter cannot serve
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
    $error("divider width out of range");
  end
  // Prescale strobe is every eighth bus clock, or every clock when bypassed [RULE_04]
  assign pre_tick = prescale_i ? (pre_cnt_r == 3'(PRESCALE_RATIO - 1)) : 1'b1;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !run_i) begin
      pre_cnt_r <= 3'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end
  // Counts divisor plus one strobes; one tick marks one timing clock period [RULE_05]
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !run_i) begin
      div_cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (pre_tick) begin
      if (div_cnt_r == divisor_i) begin
        div_cnt_r <= '0;
        tick_o <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 1'b1;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> logic/nvm_clock_options.sv
// APB register block: write-once timing clock divider and reset-loaded options.
// Assumes the nonvolatile option byte, stored key and protect state are stable
// around reset release; the debug flag comes from logic on core_clk_i.
//
// Operation
// RULE_01 - The divisor-loaded flag is read-only, cleared by reset, and set by the first divider write.
// RULE_02 - Divider bits 6..0 always read back and only the first write after reset changes them.
// RULE_03 - Erase and program are refused until the divisor-loaded flag is set.
// RULE_04 - The prescale bit selects bus clock divided by eight, otherwise the bus clock itself.
// RULE_05 - The selected clock is divided by the 6-bit divisor plus one to form the timing clock.
// RULE_06 - Software picks settings giving a timing clock between 150 and 200 kHz.
// RULE_07 - Each program or erase pulse is one timing clock period, operations last whole pulses; here the first pulse can be partial.
// RULE_08 - Options are loaded from the nonvolatile source during reset only; here in the first clock after reset release.
// RULE_09 - With the key enable clear, key comparison never lifts security.
// RULE_10 - With key enable set, eight matching key bytes in order lift security until reset.
// RULE_11 - Key writes from the debug command path never count toward unlocking.
// RULE_12 - The redirect disable bit set forces default vectors, clear enables redirection.
// RULE_13 - Redirection needs protection too and never applies to the reset vector.
// RULE_14 - Bus writes to the options register have no effect.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
module nvm_clock_options #(
  parameter int OP_PULSES = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] nonvolatile_options_source_i,
  input wire logic [63:0] stored_backdoor_key_i,
  input wire logic background_debug_commands_i,
  input wire logic flash_protected_i,
  input wire logic vector_fetch_i,
  input wire logic [6:0] vector_index_i,
  input wire logic op_start_i,
  output logic op_refused_o,
  output logic op_busy_o,
  output logic op_done_o,
  output logic nvm_timing_clock_o,
  output logic secure_o,
  output logic redirect_vector_o
);
  import nvm_ctrl_pkg::*;

  logic [7:0] nvm_clock_divider_r;
  logic [7:0] nvm_options_r;
  logic rst_seen_r;
  logic key_armed_r;
  logic [3:0] key_idx_r;
  logic key_ok_r;
  logic secure_r;
  logic [15:0] pulse_cnt_r;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] key_byte;

  // Refuse pulse counts the 16-bit pulse counter cannot hold
  if (OP_PULSES < 1 || OP_PULSES > 65535) begin : g_bad_pulses
    $error("pulse count out of range");
  end

  // Simple APB slave: ready in every access phase without wait states, unmapped addresses answer with an error
  assign addr_ok = (paddr == ADDR_CLOCK_DIVIDER) || (paddr == ADDR_OPTIONS) ||
                   (paddr == ADDR_KEY_CONTROL) || (paddr == ADDR_KEY_DATA) ||
                   (paddr == ADDR_STATUS);
  assign wr_en = psel && penable && pwrite && pready && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  // Ready is asserted in the access phase, one cycle after setup
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data is captured in the setup cycle so it stands during access
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        ADDR_CLOCK_DIVIDER: prdata <= {24'h00_0000, nvm_clock_divider_r}; // [RULE_02]
        ADDR_OPTIONS: prdata <= {24'h00_0000, nvm_options_r};
        ADDR_KEY_CONTROL: prdata <= {31'h0000_0000, key_armed_r};
        ADDR_STATUS: prdata <= {28'h000_0000, key_armed_r, redirect_vector_o,
                                nvm_clock_divider_r[LOADED_FLAG_BIT], secure_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Write-once divider; the loaded flag is set by the first write whatever the data
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nvm_clock_divider_r <= CLOCK_DIVIDER_RESET; // [RULE_01]
    end else if (wr_en && paddr == ADDR_CLOCK_DIVIDER && !nvm_clock_divider_r[LOADED_FLAG_BIT]) begin
      nvm_clock_divider_r <= {1'b1, pwdata[6:0]}; // [RULE_01] [RULE_02]
    end
  end

  // Options copy: taken in the first clock after reset release, as the source
  // cannot be sampled by an asynchronous load; bus writes never reach it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rst_seen_r <= 1'b0;
      nvm_options_r <= OPTIONS_RESET;
    end else if (!rst_seen_r) begin
      rst_seen_r <= 1'b1;
      nvm_options_r <= nonvolatile_options_source_i; // [RULE_08] [RULE_14]
    end
  end

  assign key_byte = stored_backdoor_key_i[8*(KEY_BYTES-1-key_idx_r[2:0]) +: 8];

  // Backdoor key entry: arm, write eight bytes first to last, disarm to compare
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      key_armed_r <= 1'b0;
      key_idx_r <= 4'h0;
      key_ok_r <= 1'b0;
      secure_r <= 1'b1;
    end else begin
      if (wr_en && paddr == ADDR_KEY_CONTROL) begin
        key_armed_r <= pwdata[0];
        if (pwdata[0]) begin
          key_idx_r <= 4'h0;
          key_ok_r <= 1'b1;
        end else if (key_armed_r && key_ok_r && key_idx_r == 4'(KEY_BYTES) &&
                     nvm_options_r[KEY_ENABLE_BIT] && rst_seen_r) begin
          secure_r <= 1'b0; // [RULE_09] [RULE_10]
        end
      end
      // Debug-path writes poison the attempt rather than being skipped
      if (wr_en && paddr == ADDR_KEY_DATA && key_armed_r) begin
        if (background_debug_commands_i || key_idx_r >= 4'(KEY_BYTES)) begin
          key_ok_r <= 1'b0; // [RULE_11]
        end else begin
          key_idx_r <= key_idx_r + 4'h1;
          if (pwdata[7:0] != key_byte) begin
            key_ok_r <= 1'b0; // [RULE_10]
          end
        end
      end
    end
  end

  // Redirection only for interrupt vectors, never the reset vector slot
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      redirect_vector_o <= 1'b0;
    end else begin
      redirect_vector_o <= vector_fetch_i && !nvm_options_r[REDIRECT_DISABLE_BIT] &&
                           flash_protected_i && (vector_index_i != 7'h7f); // [RULE_12] [RULE_13]
    end
  end

  // Timing clock runs only once the divisor is loaded
  nvm_timing_divider #(
    .DIV_W(DIV_WIDTH)
  ) u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(nvm_clock_divider_r[LOADED_FLAG_BIT]),
    .prescale_i(nvm_clock_divider_r[PRESCALE_BIT]),
    .divisor_i(nvm_clock_divider_r[DIV_WIDTH-1:0]),
    .tick_o(tick)
  );

  // Operation sequencer: refused before the divisor is loaded, else ends on the
  // OP_PULSES-th timing tick after start; the divider free-runs, so the first pulse can be partial
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      op_busy_o <= 1'b0;
      op_done_o <= 1'b0;
      op_refused_o <= 1'b0;
      pulse_cnt_r <= 16'h0000;
    end else begin
      op_done_o <= 1'b0;
      op_refused_o <= op_start_i && !op_busy_o && !nvm_clock_divider_r[LOADED_FLAG_BIT]; // [RULE_03]
      if (op_start_i && !op_busy_o && nvm_clock_divider_r[LOADED_FLAG_BIT]) begin
        op_busy_o <= 1'b1;
        pulse_cnt_r <= 16'h0000;
      end else if (op_busy_o && tick) begin
        if (pulse_cnt_r == 16'(OP_PULSES - 1)) begin
          op_busy_o <= 1'b0;
          op_done_o <= 1'b1; // [RULE_07]
        end else begin
          pulse_cnt_r <= pulse_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Timing clock output is the tick registered one bus clock later: one bus-clock pulse per timing clock period
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      nvm_timing_clock_o <= 1'b0;
      secure_o <= 1'b1;
    end else begin
      nvm_timing_clock_o <= tick; // [RULE_07]
      secure_o <= secure_r;
    end
  end
endmodule

// >>> bench/nvm_clock_options_props.sv
// Checker for the divider and options register block.
// Sees only the block's ports; one clock, synchronous active-low reset.
`timescale 1ns/1ns
module nvm_clock_options_props (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] nonvolatile_options_source_i,
  input wire logic flash_protected_i,
  input wire logic vector_fetch_i,
  input wire logic [6:0] vector_index_i,
  input wire logic op_start_i,
  input wire logic op_refused_o,
  input wire logic op_busy_o,
  input wire logic secure_o,
  input wire logic redirect_vector_o
);
  logic ldd_r;
  logic rel_r;
  logic [7:0] opt_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the loaded flag, and the option byte taken one edge after reset
  always_ff @(posedge core_clk_i) begin
    rel_r <= rst_n_i;
    if (!rst_n_i) ldd_r <= 1'b0;
    else if (psel && penable && pwrite && pready && paddr == 12'h000) ldd_r <= 1'b1;
    if (rst_n_i && !rel_r) opt_r <= nonvolatile_options_source_i;
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready in access");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_bad_addr_err: assert property (psel && !penable && paddr == 12'h014 |=> pslverr)
    else $error("unmapped address not flagged");
  a_refuse_unloaded:
    assert property (op_start_i && !ldd_r |=> op_refused_o && !op_busy_o) else $error("op not refused");
  a_start_when_loaded:
    assert property (op_start_i && ldd_r && !op_busy_o |=> op_busy_o && !op_refused_o) else $error("op not started");
  a_unlock_needs_key:
    assert property ($fell(secure_o) |-> opt_r[7]) else $error("unlocked with key disabled");
  a_redirect_off:
    assert property (rel_r && vector_fetch_i && (!flash_protected_i || vector_index_i == 7'h7f || opt_r[6])
      |=> !redirect_vector_o) else $error("vector redirected wrongly");
  a_redirect_on:
    assert property (rel_r && vector_fetch_i && flash_protected_i && vector_index_i != 7'h7f && !opt_r[6]
      |=> redirect_vector_o) else $error("vector not redirected");
endmodule
bind nvm_clock_options nvm_clock_options_props props (.*);

// >>> bench/nvm_clock_options_test.sv
// Self-checking bench for the divider and options register block.
// The bench drives APB and all side inputs itself; one 20 MHz clock.
`timescale 1ns/1ns
module nvm_clock_options_test;
  import nvm_ctrl_pkg::*;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, op_refused_o, op_busy_o, op_done_o, nvm_timing_clock_o, secure_o, redirect_vector_o;
  logic [7:0] nonvolatile_options_source_i = '0;
  logic [63:0] stored_backdoor_key_i = '0;
  logic background_debug_commands_i = 1'b0, flash_protected_i = 1'b0, vector_fetch_i = 1'b0, op_start_i = 1'b0;
  logic [6:0] vector_index_i = '0;
  logic [31:0] eq[$], mq[$];
  logic [1:0] oq[$];
  int failures = 0, num_checks = 0, seed = 79841, n;
  always #25 core_clk_i = ~core_clk_i;
  nvm_clock_options #(.OP_PULSES(2)) dut (.*);
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Watcher: each read answer or op outcome is paired with the oldest note
  always @(posedge core_clk_i) begin
    if (psel && penable && pready && !pwrite) chk("prdata", prdata & mq.pop_front(), eq.pop_front());
    if (op_refused_o || op_done_o) chk("op", {op_refused_o, op_done_o}, oq.pop_front());
    // Addresses above the status register are unmapped and must answer with an error
    if (psel && penable && pready) chk("pslverr", {31'h0, pslverr}, {31'h0, paddr > ADDR_STATUS});
  end
  // Holds the request until pready is seen, then releases for one edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i) penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1) @(posedge core_clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m = 32'hff);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, '0);
  endtask
  task automatic rst(logic [7:0] s);
    rst_n_i <= 1'b0;
    nonvolatile_options_source_i <= s;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic op(logic [1:0] e);
    oq.push_back(e);
    op_start_i <= 1'b1;
    @(posedge core_clk_i) op_start_i <= 1'b0;
    while (op_busy_o !== 1'b0 || oq.size() != 0) @(posedge core_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    stored_backdoor_key_i = {$random(seed), $random(seed)};
    rst(8'h3f);
    rd(ADDR_CLOCK_DIVIDER, 32'h0);
    rd(ADDR_PROTECT, 32'h0, 32'hffffffff);
    op(2'b10);
    $display("reset and refusal test done");
    // Write once: the second divider write and any options write must vanish.
    // Pass 0 bypasses the prescaler with no operation; pass 1 uses a legal
    // timing clock, since an operation may only start inside the window.
    for (int p = 0; p < 2; p++) begin
      if (p == 1) rst(8'h3f);
      r = $random(seed);
      r[6] = 1'b0;
      if (p == 1) r[6:0] = {1'b1, 2'b00, 2'b11, r[1:0]};
      apb(1'b1, ADDR_CLOCK_DIVIDER, {24'h0, r[7:0]});
      apb(1'b1, ADDR_CLOCK_DIVIDER, {24'h0, ~r[7:0]});
      apb(1'b1, ADDR_OPTIONS, 32'h0);
      rd(ADDR_CLOCK_DIVIDER, {24'h0, 1'b1, r[6:0]});
      rd(ADDR_OPTIONS, 32'h3f);
      while (nvm_timing_clock_o !== 1'b1) @(posedge core_clk_i);
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
      end while (nvm_timing_clock_o !== 1'b1);
      chk("tick period", n, (r[6] ? 8 : 1) * (r[5:0] + 1));
      if (p == 1) op(2'b01);
      rd(ADDR_STATUS, 32'h3, 32'h3);
    end
    $display("divider test done");
    // Key cases: disabled, good, from debug path, wrong byte
    for (int i = 0; i < 4; i++) begin
      rst({i != 0, i[0], 6'h15});
      rd(ADDR_OPTIONS, {24'h0, nonvolatile_options_source_i});
      background_debug_commands_i <= (i == 2);
      apb(1'b1, ADDR_KEY_CONTROL, 32'h1);
      for (int b = 0; b < KEY_BYTES; b++)
        apb(1'b1, ADDR_KEY_DATA, {24'h0, stored_backdoor_key_i[63-8*b -: 8] ^ ((i == 3 && b == 5) ? 8'h5a : 8'h00)});
      apb(1'b1, ADDR_KEY_CONTROL, 32'h0);
      background_debug_commands_i <= 1'b0;
      rd(ADDR_STATUS, {31'h0, i != 1}, 32'h1);
      chk("secure", {31'h0, secure_o}, {31'h0, i != 1});
      r = $random(seed);
      flash_protected_i <= r[0];
      vector_index_i <= (i == 3) ? 7'h7f : r[7:1];
      vector_fetch_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      chk("redirect", {31'h0, redirect_vector_o}, {31'h0, flash_protected_i && vector_index_i != 7'h7f && !i[0]});
      vector_fetch_i <= 1'b0;
      $display("key case %0d done", i);
    end
    tally_and_finish;
  end
  // Whole run is at most four slow and two fast tick periods plus about two hundred bus cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    tally_and_finish;
  end
endmodule
